// File: src/ccrr_core.sv
// Purpose: Core clock ratio capture, reset sequencing, pad release and debug halt
// Assumes: Reset pin, PLL lock and DRAM power-on inputs arrive asynchronously
// Notes:   The PLL itself is analogue; this block programs and supervises it
`timescale 1ns/1ps

// Contract
// RULE1: Core clock is n times system clock; 000 gives 4
// RULE2: Decode codes 001-110 to 5,6,7,8,10,12; 111 reserved
// RULE3: Straps change only during reset, tied static
// RULE4: One instruction per core clock cycle
// RULE5: Reset returns state to known, execution idle
// RULE6: Reset held asserted a type-dependent minimum time; code has no timer, leaves reset when pin rises
// RULE7: Drive reset-done output when sequence finishes
// RULE8: DRAM power-on reset from reset-done loopback
// RULE9: Synchronise every asynchronous input before use
// RULE10: All outputs high impedance during reset
// RULE11: Outputs may float during normal operation too
// RULE12: Halt during debug transfer, resume full speed
// RULE13: Core clock made by PLL from system clock
// RULE14: System clock at most quarter core clock
// RULE15: Capture straps in reset, hold until next
module ccrr_core
   import ccrr_pkg::*;
(
   input wire logic i_sys_clk,               // System clock, 250 MHz
   input wire logic i_rst_b,                 // Synchronous chip reset, active low
   input wire logic i_rst_in_b,              // Reset pin, asynchronous, active low
   input wire logic [2:0] i_core_ratio_straps, // Ratio strap pins
   input wire logic i_pll_locked_async,      // PLL lock indication, asynchronous
   input wire logic i_por_in_b,              // DRAM power-on reset pin, async, low
   input wire logic i_dbg_xfer,              // Debug port transfer in progress
   input wire logic i_pad_release,           // Request to float outputs in run
   output logic [3:0] o_core_mult,           // PLL feedback multiplier
   output logic o_pll_en,                    // PLL enable
   output logic [3:0] o_instr_per_sclk,      // Instructions per system clock
   output logic o_ratio_bad,                 // Reserved strap code captured
   output logic o_core_run,                  // Core may execute
   output logic o_rst_done_b,                // Reset complete pin, low in reset
   output logic o_dram_rst_b,                // DRAM reset, low while in reset
   output logic o_pad_oe                     // Output pad enable, high drives
);

   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   logic [2:0] sync1_q;                      // First stage, read only by stage two
   logic [2:0] sync2_q;                      // Second stage, safe to use
   logic [2:0] sync1_d;
   logic [2:0] sync2_d;
   logic rst_pin_act;                        // Reset pin asserted, synchronised
   logic pll_lock;                           // Lock, synchronised
   logic por_ok;                             // DRAM power-on released

   // Both stages move every edge; stage one feeds only stage two
   // Costs two cycles of latency on every pin, which the sequencer absorbs
   always_comb
   begin
      sync1_d = {i_por_in_b, i_pll_locked_async, i_rst_in_b}; // [RULE9]
      sync2_d = sync1_q;                                      // [RULE9]
   end

   // Register the chains; chip reset forces reset asserted
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_b)
      begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
      end
      else
      begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   assign rst_pin_act = !sync2_q[0];
   assign pll_lock = sync2_q[1];
   assign por_ok = sync2_q[2];

   // ----------------------------------------
   // Strap capture and decode
   // ----------------------------------------
   ccrr_cfg_type cfg_q;                      // Held ratio configuration
   ccrr_cfg_type cfg_d;

   // Straps are static by board wiring, so they are sampled directly; they
   // are only looked at while reset is held and then frozen until the next
   always_comb
   begin
      cfg_d = cfg_q;
      if (rst_pin_act)                                        // [RULE15] [RULE3]
      begin
         cfg_d.code = i_core_ratio_straps;
         cfg_d.rsvd = 1'b0;
         case (i_core_ratio_straps)                           // [RULE1] [RULE2]
            CODE_X4: cfg_d.mult = MULT_4;
            CODE_X5: cfg_d.mult = MULT_5;
            CODE_X6: cfg_d.mult = MULT_6;
            CODE_X7: cfg_d.mult = MULT_7;
            CODE_X8: cfg_d.mult = MULT_8;
            CODE_X10: cfg_d.mult = MULT_10;
            CODE_X12: cfg_d.mult = MULT_12;
            default:
            begin
               // Reserved: fall back to the default ratio and flag it
               cfg_d.mult = MULT_4;
               cfg_d.rsvd = 1'b1;
            end
         endcase
      end
   end

   // Hold the captured configuration
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_b)
      begin
         cfg_q <= CFG_RST;
      end
      else
      begin
         cfg_q <= cfg_d;
      end
   end

   // ----------------------------------------
   // Reset sequencer
   // ----------------------------------------
   ccrr_state_type state_q;                  // Sequencer state
   ccrr_state_type state_d;
   logic [CNT_W-1:0] cnt_q;                  // Settle counter
   logic [CNT_W-1:0] cnt_d;
   logic done_q;                             // Reset-done level
   logic done_d;
   logic oe_q;                               // Pad enable
   logic oe_d;

   // Reset wins over everything; lock must hold through the settle time
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      done_d = done_q;
      case (state_q)
         ST_RESET:
         begin
            cnt_d = '0;
            done_d = 1'b0;
            if (!rst_pin_act)
            begin
               state_d = ST_LOCK;
            end
         end
         ST_LOCK:
         begin
            // Lock loss restarts the settle wait
            if (!pll_lock)                                    // [RULE13]
            begin
               cnt_d = '0;
            end
            else if (cnt_q == CNT_W'(SETTLE_CYC - 1))
            begin
               state_d = ST_RUN;
               done_d = 1'b1;                                 // [RULE7]
            end
            else
            begin
               cnt_d = cnt_q + CNT_W'(1);
            end
         end
         ST_RUN:
         begin
            if (i_dbg_xfer)                                   // [RULE12]
            begin
               state_d = ST_HALT;
            end
         end
         ST_HALT:
         begin
            // Core timing untouched; PLL keeps running, so resume is at speed
            if (!i_dbg_xfer)                                  // [RULE12]
            begin
               state_d = ST_RUN;
            end
         end
         default:
         begin
            state_d = ST_RESET;
            cnt_d = '0;
            done_d = 1'b0;
         end
      endcase
      if (rst_pin_act)                                        // [RULE5]
      begin
         state_d = ST_RESET;
         cnt_d = '0;
         done_d = 1'b0;
      end
      // Pads float until reset-done rises and whenever release is asked for;
      // tying enable to the done level keeps the pins quiet through PLL settle,
      // so no half-configured value ever reaches the board
      oe_d = done_d && !i_pad_release;                        // [RULE10] [RULE11]
   end

   // Register sequencer state
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_b)
      begin
         state_q <= ST_RESET;
         cnt_q <= '0;
         done_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         done_q <= done_d;
         oe_q <= oe_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_core_mult = cfg_q.mult;                           // [RULE1] [RULE13]
   assign o_pll_en = (state_q != ST_RESET);
   assign o_instr_per_sclk = (state_q == ST_RUN) ? cfg_q.mult : 4'h0; // [RULE4]
   assign o_ratio_bad = cfg_q.rsvd;
   assign o_core_run = (state_q == ST_RUN);
   assign o_rst_done_b = done_q;
   // DRAM leaves reset only once the looped-back pin says so
   assign o_dram_rst_b = por_ok;                              // [RULE8]
   assign o_pad_oe = oe_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   // Chip reset masks every check; some checks sample the raw reset pin and allow for its synchroniser delay

   sequence s_pin_low3;
      (!i_rst_in_b)[*3];
   endsequence

   sequence s_halt_entry;
      o_core_run ##1 i_dbg_xfer;
   endsequence

   sequence s_halt_exit;
      (state_q == ST_HALT) ##1 o_core_run;
   endsequence

   a_ratio_hold: assert property (!rst_pin_act && $past(!rst_pin_act) |-> $stable(cfg_q)) // [RULE15]
      else $error("ratio changed outside reset");

   a_ratio_decode: assert property (o_core_run |-> // [RULE2]
      (cfg_q.code == CODE_X10 ? o_core_mult == MULT_10 :
       cfg_q.code == CODE_X12 ? o_core_mult == MULT_12 :
       cfg_q.code == CODE_RSVD ? o_ratio_bad :
       o_core_mult == {1'b0, cfg_q.code} + MULT_4))
      else $error("ratio decode wrong");

   a_instr_rate: assert property (o_core_run |-> o_instr_per_sclk == o_core_mult) // [RULE4]
      else $error("instruction rate not core clock");

   a_reset_idle: assert property (s_pin_low3 |=> !o_core_run && !o_rst_done_b ##1 !o_core_run) // [RULE5]
      else $error("core not idle in reset");

   a_sync_latency: assert property ($fell(i_rst_in_b) |=> o_core_run == $past(o_core_run, 1)) // [RULE9]
      else $error("reset pin used before synchroniser");

   a_done_settle: assert property ($rose(o_rst_done_b) |-> // [RULE7]
      $past(pll_lock, 1) && $past(cnt_q, 1) == CNT_W'(SETTLE_CYC - 1))
      else $error("reset done before settle time");

   a_pads_float: assert property (!o_rst_done_b |-> !o_pad_oe) // [RULE10]
      else $error("pad driven before reset done");

   a_pads_release: assert property (i_pad_release |=> !o_pad_oe) // [RULE11]
      else $error("pad driven during release");

   a_pads_drive: assert property (o_core_run && !i_pad_release && !rst_pin_act |=> o_pad_oe) // [RULE11]
      else $error("pad not driven in run");

   a_debug_halt: assert property (s_halt_entry |=> !o_core_run && o_rst_done_b) // [RULE12]
      else $error("core ran during debug transfer");

   a_debug_resume: assert property ((state_q == ST_HALT) && !i_dbg_xfer && !rst_pin_act |=> o_core_run) // [RULE12]
      else $error("core did not resume after debug");

   a_resume_speed: assert property (s_halt_exit |-> // [RULE12]
      o_instr_per_sclk == o_core_mult && $stable(o_core_mult))
      else $error("resume not at full rate");

   a_pll_enable: assert property (o_core_run |-> o_pll_en && o_rst_done_b) // [RULE13]
      else $error("core ran without PLL");

   a_dram_por: assert property ((!i_por_in_b)[*3] |-> !o_dram_rst_b) // [RULE8]
      else $error("DRAM left reset early");

endmodule

// File: pkg/ccrr_pkg.sv
// Purpose: Shared constants and types for core clock ratio and reset sequencing
// Assumes: One system clock at 250 MHz, synchronous active-low chip reset
// Notes:   Multipliers are the core clock to system clock factors per strap code
package ccrr_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int SYS_CLK_MHZ = 250;              // System clock rate
   localparam int PLL_SETTLE_NS = 100;            // Least settle time after lock
   localparam int SETTLE_CYC =
      (PLL_SETTLE_NS * SYS_CLK_MHZ + 999) / 1000; // Rounded up to whole cycles
   localparam int CNT_W = 5;                      // Settle counter width

   // ----------------------------------------
   // Strap codes and multipliers
   // ----------------------------------------
   localparam logic [2:0] CODE_X4 = 3'h0;         // Default code
   localparam logic [2:0] CODE_X5 = 3'h1;
   localparam logic [2:0] CODE_X6 = 3'h2;
   localparam logic [2:0] CODE_X7 = 3'h3;
   localparam logic [2:0] CODE_X8 = 3'h4;
   localparam logic [2:0] CODE_X10 = 3'h5;
   localparam logic [2:0] CODE_X12 = 3'h6;
   localparam logic [2:0] CODE_RSVD = 3'h7;       // Reserved code
   localparam logic [3:0] MULT_4 = 4'h4;
   localparam logic [3:0] MULT_5 = 4'h5;
   localparam logic [3:0] MULT_6 = 4'h6;
   localparam logic [3:0] MULT_7 = 4'h7;
   localparam logic [3:0] MULT_8 = 4'h8;
   localparam logic [3:0] MULT_10 = 4'hA;
   localparam logic [3:0] MULT_12 = 4'hC;
   localparam logic [3:0] MULT_RST = MULT_4;      // Value before first capture

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed
   {
      logic [2:0] code;                           // Captured strap code
      logic [3:0] mult;                           // Decoded multiplier
      logic rsvd;                                 // Reserved code seen
   } ccrr_cfg_type;

   localparam ccrr_cfg_type CFG_RST = '{code: CODE_X4, mult: MULT_RST, rsvd: 1'b0};

   typedef enum logic [3:0]
   {
      ST_RESET = 4'h1,                            // Held in reset, idle
      ST_LOCK = 4'h2,                             // Waiting for PLL lock and settle
      ST_RUN = 4'h4,                              // Core executing
      ST_HALT = 4'h8                              // Halted for debug transfer
   } ccrr_state_type;

endpackage

// File: test/ccrr_board_model.sv
// Purpose: Board-side model: reset pin source, strap wiring, PLL lock, DRAM loopback
// Assumes: Bench requests pin level, strap code and lock speed
// Notes:   Lock is reported a fixed count after the PLL is enabled
`timescale 1ns/1ps
module ccrr_board_model
   import ccrr_pkg::*;
(
   input wire logic i_sys_clk,     // System clock
   input wire logic i_pin_b_req,   // Requested reset pin level
   input wire logic [2:0] i_code_req, // Requested strap code
   input wire logic i_lock_slow,   // Slow PLL lock
   input wire logic i_pll_en,      // PLL enable from device
   input wire logic i_rst_done_b,  // Reset-done from device
   output logic o_rst_in_b,        // Reset pin
   output logic [2:0] o_straps,    // Strap pins
   output logic o_pll_locked,      // PLL lock
   output logic o_por_b            // DRAM power-on pin
);
   logic [5:0] lock_cnt_q; // Cycles since PLL enable

   // ----------------------------------------
   // Pin and strap drive
   // ----------------------------------------
   // Straps move only while the pin is low, so a running device never sees a change
   always_ff @(posedge i_sys_clk)
   begin
      o_rst_in_b <= i_pin_b_req;
      if (!i_pin_b_req)
      begin
         o_straps <= i_code_req;
      end
   end

   // ----------------------------------------
   // PLL lock model
   // ----------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_pll_en)
      begin
         lock_cnt_q <= 6'h00;
      end
      else if (lock_cnt_q != 6'h3F)
      begin
         lock_cnt_q <= lock_cnt_q + 6'h01;
      end
   end
   // Lock follows enable only; a dropped enable drops lock at once
   assign o_pll_locked = i_pll_en && (lock_cnt_q >= (i_lock_slow ? 6'h14 : 6'h03));
   assign o_por_b = i_rst_done_b;
endmodule

// File: test/tb_ccrr_core.sv
// Purpose: Self-checking bench for ratio capture and reset sequencing
// Assumes: Partner model drives pins; bench drives debug and pad release
// Notes:   Straps are only changed while the reset pin is held low
`timescale 1ns/1ps
module tb_ccrr_core;
   import ccrr_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic pin_b = 1'b0;
   logic lock_slow = 1'b0;
   logic dbg = 1'b0;
   logic rel = 1'b0;
   logic [2:0] code = 3'h0;
   logic rst_in_b, locked, por_b, pll_en, bad, run, done_b, dram_b, oe;
   logic [2:0] straps;
   logic [3:0] mult, ipc;
   int n_fail = 0;
   int compares = 0;
   // Every strap code with its multiplier, reserved 111 included with its flag
   ccrr_cfg_type rows [8] = '{'{3'h0, 4'h4, 1'b0}, '{3'h1, 4'h5, 1'b0}, '{3'h2, 4'h6, 1'b0},
      '{3'h3, 4'h7, 1'b0}, '{3'h4, 4'h8, 1'b0}, '{3'h5, 4'hA, 1'b0}, '{3'h6, 4'hC, 1'b0},
      '{3'h7, 4'h4, 1'b1}};

   always #2 clk = ~clk;

   ccrr_board_model u_ccrr_board_model (.i_sys_clk(clk), .i_pin_b_req(pin_b), .i_code_req(code),
      .i_lock_slow(lock_slow), .i_pll_en(pll_en), .i_rst_done_b(done_b), .o_rst_in_b(rst_in_b),
      .o_straps(straps), .o_pll_locked(locked), .o_por_b(por_b));
   ccrr_core u_ccrr_core (.i_sys_clk(clk), .i_rst_b(rst_b), .i_rst_in_b(rst_in_b),
      .i_core_ratio_straps(straps), .i_pll_locked_async(locked), .i_por_in_b(por_b),
      .i_dbg_xfer(dbg), .i_pad_release(rel), .o_core_mult(mult), .o_pll_en(pll_en),
      .o_instr_per_sclk(ipc), .o_ratio_bad(bad), .o_core_run(run), .o_rst_done_b(done_b),
      .o_dram_rst_b(dram_b), .o_pad_oe(oe));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   // Inputs change 1 ns after the rising edge
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task close_out;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Hold the pin low with a strap code, then wait for run under a bound
   task boot(input logic [2:0] c, input int tmin);
      int t;
      t = 0;
      code = c;
      pin_b = 1'b0;
      step(6);
      chk("oe", oe, 0);
      chk("run", run, 0);
      chk("done", done_b, 0);
      chk("dram", dram_b, 0);
      chk("ipc", ipc, 0);
      pin_b = 1'b1;
      while (run !== 1'b1 && t < 200)
      begin
         step(1);
         t++;
      end
      chk("settle", 4'(t >= tmin), 1);
      step(3);
      chk("done", done_b, 1);
      chk("dram", dram_b, 1);
      chk("oe", oe, 1);
      chk("pll", pll_en, 1);
      chk("min ratio", 4'(mult >= 4'h4), 1);
   endtask

   initial
   begin
      #40000;
      n_fail++;
      close_out;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      step(5);
      chk("rst mult", mult, 4'h4);
      chk("rst pll", pll_en, 0);
      rst_b = 1'b1;
      foreach (rows[i])
      begin
         boot(rows[i].code, SETTLE_CYC);
         chk("mult", mult, rows[i].mult);
         chk("bad", bad, rows[i].rsvd);
         chk("ipc", ipc, rows[i].mult);
         $display("test code %0d done", i);
      end
      // Debug halt and resume
      dbg = 1'b1;
      step(2);
      chk("halt run", run, 0);
      chk("halt ipc", ipc, 0);
      dbg = 1'b0;
      step(2);
      chk("resume run", run, 1);
      chk("resume ipc", ipc, 4'h4);
      $display("test debug done");
      // Pads float while running
      rel = 1'b1;
      step(2);
      chk("rel oe", oe, 0);
      chk("rel run", run, 1);
      rel = 1'b0;
      $display("test release done");
      // Slow lock delays run
      lock_slow = 1'b1;
      boot(3'h6, SETTLE_CYC + 20);
      chk("slow mult", mult, 4'hC);
      lock_slow = 1'b0;
      $display("test slow lock done");
      // Chip reset in mid-run, then recovery
      // Board holds the pin low across chip reset, as at power-up
      pin_b = 1'b0;
      rst_b = 1'b0;
      step(2);
      chk("cr mult", mult, 4'h4);
      chk("cr run", run, 0);
      chk("cr oe", oe, 0);
      rst_b = 1'b1;
      boot(3'h4, SETTLE_CYC);
      chk("cr2 mult", mult, 4'h8);
      $display("test chip reset done");
      close_out;
   end
endmodule
